// File: pgdfc_bank.sv
// Paged power-good delay, inductor, margin and output fault filter bank.
//
// Summary of operation
// RL1: Each output waits the programmed delay after crossing the good threshold before its good pin rises.
// RL2: The delay spans zero to 500 s in steps of 125 ns; the code times each step as seven 20 ns cycles, 140 ns, so the top is 560 s.
// RL3: Software is expected to program at least 1 ms of delay for debounce, but nothing enforces it.
// RL4: The delay setting resets to BA00h, which is 1 ms.
// RL5: Delay, inductor and margin words hold a signed exponent over a signed mantissa, value Y times 2^N.
// RL6: Every setting is kept per output and chosen by the addressed page.
// RL7: All settings read back and writes are blocked while write protection is on.
// RL8: The inductor value, in microhenries, feeds the ripple-current calculations.
// RL9: The inductor setting resets to B23Dh and accepts zero to 100 uH; the code stores any value written, without a range check.
// RL10: With margin ratio enabled the margin voltages sit the programmed percentage above and below nominal.
// RL11: The margin percentage resets to CA80h, five percent, and accepts zero to fifty percent; the code stores any value written, without a range check.
// RL12: On overvoltage shutdown the low-side device turns on only when fault config bit 7 is one.
// RL13: A voltage fault is declared after N+1 consecutive violations, N from fault config bits 3:0.
// RL14: The fault config resets to 00h and bits 6:4 have no effect.
// RL15: The margin percentage applies only while user config bit 4 is set.
// RL16: Falling below the threshold before the delay ends restarts the count with the pin held low.
`timescale 1ns/1ps
`include "pgdfc_consts.svh"
module pgdfc_bank (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic page_i,
  input wire logic [7:0] cmd_i,
  input wire logic wr_i,
  input wire pgdfc_pkg::pgdfc_word_t wdata_i,
  input wire logic write_protect_i,
  input wire logic [1:0] user_margin_cfg_i,
  input wire logic [1:0] above_good_i,
  input wire logic [1:0] ov_violation_i,
  input wire logic [1:0] uv_violation_i,
  input wire logic [1:0] sample_i,
  input wire pgdfc_pkg::pgdfc_word_t vout_nominal_0_i,
  input wire pgdfc_pkg::pgdfc_word_t vout_nominal_1_i,
  output pgdfc_pkg::pgdfc_word_t rdata_o,
  output logic cmd_refused_o,
  output logic [1:0] output_good_pin_o,
  output logic [1:0] ov_fault_o,
  output logic [1:0] uv_fault_o,
  output logic [1:0] lowside_on_o,
  output logic [1:0] margin_ratio_active_o,
  output pgdfc_pkg::pgdfc_word_t margin_ratio_0_o,
  output pgdfc_pkg::pgdfc_word_t margin_ratio_1_o,
  output pgdfc_pkg::pgdfc_word_t inductor_0_o,
  output pgdfc_pkg::pgdfc_word_t inductor_1_o
);
  import pgdfc_pkg::*;

  // =====================================================================
  // Synchronise the analog comparator levels and the strap-like config pins.
  logic [1:0] above_m, above_s, ov_m, ov_s, uv_m, uv_s, smp_m, smp_s, ucfg_m, ucfg_s;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      above_m <= 2'h0;
      above_s <= 2'h0;
      ov_m <= 2'h0;
      ov_s <= 2'h0;
      uv_m <= 2'h0;
      uv_s <= 2'h0;
      smp_m <= 2'h0;
      smp_s <= 2'h0;
      ucfg_m <= 2'h0;
      ucfg_s <= 2'h0;
    end else begin
      above_m <= above_good_i;
      above_s <= above_m;
      ov_m <= ov_violation_i;
      ov_s <= ov_m;
      uv_m <= uv_violation_i;
      uv_s <= uv_m;
      smp_m <= sample_i;
      smp_s <= smp_m;
      ucfg_m <= user_margin_cfg_i;
      ucfg_s <= ucfg_m;
    end
  end

  // Edge detect on the synchronised sample strobe; one violation counted per sample.
  logic [1:0] smp_d;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_d <= 2'h0;
    end else begin
      smp_d <= smp_s;
    end
  end

  // =====================================================================
  // Paged register storage, one entry per output.
  pgdfc_word_t pg_delay [2];
  pgdfc_word_t inductor [2];
  pgdfc_word_t margin [2];
  pgdfc_byte_t fault_cfg [2];
  logic wr_ok;
  assign wr_ok = wr_i && !write_protect_i; // [RL7]

  // Writes land in the addressed page only; reset values are the documented defaults.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 2; i++) begin
        pg_delay[i] <= `PGDFC_RST_PG_DELAY; // [RL4]
        inductor[i] <= `PGDFC_RST_INDUCTOR; // [RL9]
        margin[i] <= `PGDFC_RST_MARGIN; // [RL11]
        fault_cfg[i] <= `PGDFC_RST_FAULT_CFG; // [RL14]
      end
    end else if (wr_ok) begin
      case (cmd_i) // [RL6]
        `PGDFC_CMD_PG_DELAY: pg_delay[page_i] <= wdata_i;
        `PGDFC_CMD_INDUCTOR: inductor[page_i] <= wdata_i;
        `PGDFC_CMD_MARGIN: margin[page_i] <= wdata_i;
        `PGDFC_CMD_FAULT_CFG: fault_cfg[page_i] <= wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Read mux is registered; unknown commands read zero and flag refusal when written, as do protected writes.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
      cmd_refused_o <= 1'b0;
    end else begin
      cmd_refused_o <= wr_i && write_protect_i; // [RL7]
      case (cmd_i)
        `PGDFC_CMD_PG_DELAY: rdata_o <= pg_delay[page_i];
        `PGDFC_CMD_INDUCTOR: rdata_o <= inductor[page_i];
        `PGDFC_CMD_MARGIN: rdata_o <= margin[page_i];
        `PGDFC_CMD_FAULT_CFG: rdata_o <= {8'h00, fault_cfg[page_i]};
        default: begin
          rdata_o <= 16'h0000;
          cmd_refused_o <= wr_i || write_protect_i & 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // Linear-11 delay to 125 ns steps: mantissa is in ms, so steps = Y * 8000 * 2^N.
  // Negative mantissas are treated as zero delay; results saturate at the 500 s limit.
  function automatic logic [31:0] delay_steps(input pgdfc_word_t w); // [RL5]
    logic signed [4:0] n;
    logic signed [10:0] y;
    logic [47:0] base;
    logic [47:0] val;
    n = w[15:11];
    y = w[10:0];
    base = 48'(y < 0 ? 0 : y) * 48'd8000;
    val = (n < 0) ? (base >> (-n)) : (base << n);
    if (val > 48'(`PGDFC_MAX_STEPS)) begin
      delay_steps = `PGDFC_MAX_STEPS; // [RL2]
    end else begin
      delay_steps = val[31:0];
    end
  endfunction

  // =====================================================================
  // Per-output power-good qualification and fault filtering.
  localparam int STEP_CYC = `PGDFC_STEP_CYCLES;
  pgdfc_pg_e pg_state [2];
  logic [31:0] step_cnt [2];
  logic [2:0] sub_cnt [2];
  logic [4:0] ov_cnt [2];
  logic [4:0] uv_cnt [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      logic [31:0] target;
      logic [4:0] need;
      logic smp_evt;
      assign target = delay_steps(pg_delay[g]);
      assign need = 5'(fault_cfg[g][`PGDFC_FLT_COUNT_MSB:0]) + 5'd1; // [RL13]
      assign smp_evt = smp_s[g] && !smp_d[g];

      // Delay machine; the count restarts whenever the output drops below threshold.
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pg_state[g] <= PGDFC_PG_LOW;
          step_cnt[g] <= 32'h0000_0000;
          sub_cnt[g] <= 3'h0;
          output_good_pin_o[g] <= 1'b0;
        end else begin
          case (pg_state[g])
            PGDFC_PG_LOW: begin
              step_cnt[g] <= 32'h0000_0000;
              sub_cnt[g] <= 3'h0;
              output_good_pin_o[g] <= 1'b0;
              if (above_s[g]) begin
                pg_state[g] <= PGDFC_PG_WAIT;
              end
            end
            PGDFC_PG_WAIT: begin
              if (!above_s[g]) begin
                pg_state[g] <= PGDFC_PG_LOW; // [RL16]
              end else if (step_cnt[g] >= target) begin
                pg_state[g] <= PGDFC_PG_GOOD;
                output_good_pin_o[g] <= 1'b1; // [RL1]
              end else if (sub_cnt[g] == 3'(STEP_CYC - 1)) begin
                sub_cnt[g] <= 3'h0;
                step_cnt[g] <= step_cnt[g] + 32'h0000_0001; // [RL2]
              end else begin
                sub_cnt[g] <= sub_cnt[g] + 3'h1;
              end
            end
            PGDFC_PG_GOOD: begin
              if (!above_s[g]) begin
                pg_state[g] <= PGDFC_PG_LOW;
                output_good_pin_o[g] <= 1'b0;
              end
            end
            default: pg_state[g] <= PGDFC_PG_LOW;
          endcase
        end
      end

      // Consecutive-violation filters; a clean sample clears the run. Bits 6:4 are ignored.
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ov_cnt[g] <= 5'h00;
          uv_cnt[g] <= 5'h00;
          ov_fault_o[g] <= 1'b0;
          uv_fault_o[g] <= 1'b0;
          lowside_on_o[g] <= 1'b0;
        end else if (smp_evt) begin
          ov_cnt[g] <= ov_s[g] ? ((ov_cnt[g] < need) ? ov_cnt[g] + 5'h01 : ov_cnt[g]) : 5'h00;
          uv_cnt[g] <= uv_s[g] ? ((uv_cnt[g] < need) ? uv_cnt[g] + 5'h01 : uv_cnt[g]) : 5'h00;
          ov_fault_o[g] <= ov_s[g] && (ov_cnt[g] + 5'h01 >= need); // [RL13]
          uv_fault_o[g] <= uv_s[g] && (uv_cnt[g] + 5'h01 >= need); // [RL13]
          lowside_on_o[g] <= ov_s[g] && (ov_cnt[g] + 5'h01 >= need)
                             && fault_cfg[g][`PGDFC_FLT_LOWSIDE_BIT]; // [RL12]
        end
      end
    end
  endgenerate

  // =====================================================================
  // Margin ratio and inductor published to the regulation core.
  // The core multiplies nominal by (1 +/- ratio/100); a zeroed ratio means use fixed margins.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      margin_ratio_active_o <= 2'h0;
      margin_ratio_0_o <= 16'h0000;
      margin_ratio_1_o <= 16'h0000;
      inductor_0_o <= `PGDFC_RST_INDUCTOR;
      inductor_1_o <= `PGDFC_RST_INDUCTOR;
    end else begin
      margin_ratio_active_o <= ucfg_s; // [RL15]
      margin_ratio_0_o <= ucfg_s[0] ? margin[0] : 16'h0000; // [RL10]
      margin_ratio_1_o <= ucfg_s[1] ? margin[1] : 16'h0000; // [RL10]
      inductor_0_o <= inductor[0]; // [RL8]
      inductor_1_o <= inductor[1]; // [RL8]
    end
  end

  // =====================================================================
  // Checks.
  a_pg_needs_above: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    output_good_pin_o[0] |-> $past(above_s[0])) else $error("good pin high without level"); // [RL1]
  a_pg_drop_restart: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (pg_state[0] == PGDFC_PG_WAIT && !above_s[0]) |=> !output_good_pin_o[0]
    && pg_state[0] == PGDFC_PG_LOW) else $error("delay not restarted"); // [RL16]
  a_wp_blocks: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (wr_i && write_protect_i && cmd_i == `PGDFC_CMD_MARGIN && !page_i)
    |=> $stable(margin[0])) else $error("protected write landed"); // [RL7]
  a_wr_lands: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (wr_ok && cmd_i == `PGDFC_CMD_MARGIN && !page_i) |=> margin[0] == $past(wdata_i))
    else $error("margin write lost"); // [RL6]
  a_lowside_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    lowside_on_o[0] |-> ov_fault_o[0] && fault_cfg[0][7]) else $error("low side wrong"); // [RL12]
  a_ov_count: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    $rose(ov_fault_o[0]) |-> $past(ov_cnt[0]) + 5'h01 >= 5'(fault_cfg[0][3:0]) + 5'h01)
    else $error("fault too early"); // [RL13]
  a_margin_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !margin_ratio_active_o[0] |-> margin_ratio_0_o == 16'h0000) else $error("ratio leak"); // [RL15]
  a_delay_floor: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    $rose(output_good_pin_o[0]) |-> step_cnt[0] >= g_out[0].target) else $error("short delay"); // [RL2]
  c_pg_good: cover property (@(posedge clock_i) $rose(output_good_pin_o[0]));
  c_pg_restart: cover property (@(posedge clock_i) pg_state[0] == PGDFC_PG_WAIT && !above_s[0]);
  c_ov_fault: cover property (@(posedge clock_i) $rose(lowside_on_o[0]));
endmodule

// File: pgdfc_bank_tb.sv
// Self-checking testbench of the paged power-good and fault config bank.
`timescale 1ns/1ps
`include "pgdfc_consts.svh"
module pgdfc_bank_tb;
  import pgdfc_pkg::*;
  // 500 steps of 7 cycles: a 125 ns step rounds up to seven 20 ns cycles.
  localparam int DLY_CYC = 500 * 7;
  logic clock, arst_n, page, wr, wp, refused, last_refused;
  logic [7:0] cmd;
  pgdfc_word_t wdata, rdata, mr0, mr1, ind0, ind1;
  logic [1:0] umc, good_req, ov_req, uv_req, above_good, ovv, uvv, smp, pg, ovf, uvf, lso, mra;
  int mismatches, checks_done;
  pgdfc_stage_model stage_u (.clock_i(clock), .arst_n_i(arst_n), .good_req_i(good_req),
    .ov_req_i(ov_req), .uv_req_i(uv_req), .above_good_o(above_good), .ov_o(ovv),
    .uv_o(uvv), .sample_o(smp));
  pgdfc_bank dut_u (.clock_i(clock), .arst_n_i(arst_n), .page_i(page), .cmd_i(cmd),
    .wr_i(wr), .wdata_i(wdata), .write_protect_i(wp), .user_margin_cfg_i(umc),
    .above_good_i(above_good), .ov_violation_i(ovv), .uv_violation_i(uvv), .sample_i(smp),
    .vout_nominal_0_i(16'h0000), .vout_nominal_1_i(16'h0000), .rdata_o(rdata),
    .cmd_refused_o(refused), .output_good_pin_o(pg), .ov_fault_o(ovf), .uv_fault_o(uvf),
    .lowside_on_o(lso), .margin_ratio_active_o(mra), .margin_ratio_0_o(mr0),
    .margin_ratio_1_o(mr1), .inductor_0_o(ind0), .inductor_1_o(ind1));
  // ==================================================================
  // Comparison, bus access and verdict tasks.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The refusal pulse is caught in the cycle after the strobe, where it stands.
  task automatic write_reg(input logic p, input logic [7:0] c, input logic [15:0] d);
    @(posedge clock);
    page <= p;
    cmd <= c;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1 last_refused = refused;
  endtask
  task automatic check_reg(input logic p, input logic [7:0] c, input logic [15:0] e,
      input string what);
    @(posedge clock);
    page <= p;
    cmd <= c;
    repeat (2) @(posedge clock);
    #1 check(what, rdata, e);
  endtask
  // Waits out n strobes plus the sync and register delay before a look.
  task automatic samples(input int n);
    repeat (n) @(posedge smp[0]);
    repeat (6) @(posedge clock);
    #1;
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==================================================================
  // Clock, watchdog and main sequence.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Two delay waits dominate the run; 40000 cycles leaves ample slack.
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial begin
    {arst_n, page, wr, wp, cmd, wdata, umc, good_req, ov_req, uv_req} = '0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      check_reg(p[0], `PGDFC_CMD_PG_DELAY, 16'hba00, "delay reset");
      check_reg(p[0], `PGDFC_CMD_INDUCTOR, 16'hb23d, "inductor reset");
      check_reg(p[0], `PGDFC_CMD_MARGIN, 16'hca80, "margin reset");
      check_reg(p[0], `PGDFC_CMD_FAULT_CFG, 16'h0000, "fault cfg reset");
    end
    check("inductor out0", ind0, 16'hb23d);
    // Page 1 alone takes the new inductor word.
    write_reg(1'b1, `PGDFC_CMD_INDUCTOR, 16'h2a40);
    check_reg(1'b0, `PGDFC_CMD_INDUCTOR, 16'hb23d, "inductor p0");
    check_reg(1'b1, `PGDFC_CMD_INDUCTOR, 16'h2a40, "inductor p1");
    check("inductor out", {ind0 ^ 16'hb23d} | {ind1 ^ 16'h2a40}, 16'h0000);
    // Fifty percent is the top of the margin range; enable moves between pages.
    write_reg(1'b0, `PGDFC_CMD_MARGIN, 16'h0032);
    umc <= 2'h1;
    repeat (8) @(posedge clock);
    #1 check("margin act0", 16'(mra), 16'h0001);
    check("margin en0", mr0, 16'h0032);
    check("margin off1", mr1, 16'h0000);
    umc <= 2'h2;
    repeat (8) @(posedge clock);
    #1 check("margin act1", 16'(mra), 16'h0002);
    check("margin en1", mr1, 16'hca80);
    check("margin off0", mr0, 16'h0000);
    // Protected and unknown writes are refused and change nothing.
    wp <= 1'b1;
    write_reg(1'b0, `PGDFC_CMD_MARGIN, 16'h0000);
    check("refused wp", 16'(last_refused), 16'h0001);
    wp <= 1'b0;
    check_reg(1'b0, `PGDFC_CMD_MARGIN, 16'h0032, "margin kept");
    write_reg(1'b0, 8'hd5, 16'h1234);
    check("refused cmd", 16'(last_refused), 16'h0001);
    check_reg(1'b0, 8'hd5, 16'h0000, "unknown read");
    // N=3 with low-side drive: the fourth violating sample declares the fault.
    write_reg(1'b0, `PGDFC_CMD_FAULT_CFG, 16'h0083);
    check_reg(1'b0, `PGDFC_CMD_FAULT_CFG, 16'h0083, "fault cfg");
    ov_req <= 2'h1;
    @(negedge smp[0]);
    samples(3);
    check("ov after 3", 16'(ovf), 16'h0000);
    samples(1);
    check("ov after 4", 16'({ovf, lso}), 16'({2'h1, 2'h1}));
    ov_req <= 2'h0;
    @(negedge smp[0]);
    samples(1);
    check("ov cleared", 16'({ovf, lso}), 16'h0000);
    // N=0 with unused bits set and low-side drive off.
    write_reg(1'b0, `PGDFC_CMD_FAULT_CFG, 16'h0070);
    ov_req <= 2'h1;
    uv_req <= 2'h1;
    @(negedge smp[0]);
    samples(1);
    check("n0 faults", 16'({ovf, uvf, lso}), 16'({2'h1, 2'h1, 2'h0}));
    {ov_req, uv_req} <= 4'h0;
    // Zero delay gives the good pin at once.
    write_reg(1'b0, `PGDFC_CMD_PG_DELAY, 16'h0000);
    good_req <= 2'h1;
    repeat (12) @(posedge clock);
    #1 check("pg zero delay", 16'(pg), 16'h0001);
    good_req <= 2'h0;
    // 1/16 ms, below the recommended debounce, is still taken as written.
    write_reg(1'b0, `PGDFC_CMD_PG_DELAY, 16'he001);
    repeat (12) @(posedge clock);
    good_req <= 2'h1;
    repeat (DLY_CYC - 500) @(posedge clock);
    #1 check("pg early", 16'(pg), 16'h0000);
    good_req <= 2'h0;
    repeat (5) @(posedge clock);
    good_req <= 2'h1;
    repeat (DLY_CYC - 20) @(posedge clock);
    #1 check("pg restarted", 16'(pg), 16'h0000);
    repeat (50) @(posedge clock);
    #1 check("pg good", 16'(pg), 16'h0001);
    give_verdict();
  end
endmodule

// File: pgdfc_consts.svh
// Offsets, reset values, field positions and timing counts of the power-good and fault config bank.
`ifndef PGDFC_CONSTS_SVH
`define PGDFC_CONSTS_SVH
// =====================================================================
// Command codes of the paged settings.
`define PGDFC_CMD_PG_DELAY 8'hd4
`define PGDFC_CMD_INDUCTOR 8'hd6
`define PGDFC_CMD_MARGIN 8'hd7
`define PGDFC_CMD_FAULT_CFG 8'hd8
// =====================================================================
// Reset values.
`define PGDFC_RST_PG_DELAY 16'hba00
`define PGDFC_RST_INDUCTOR 16'hb23d
`define PGDFC_RST_MARGIN 16'hca80
`define PGDFC_RST_FAULT_CFG 8'h00
// =====================================================================
// Field positions.
`define PGDFC_FLT_LOWSIDE_BIT 7
`define PGDFC_FLT_COUNT_MSB 3
`define PGDFC_USER_MARGIN_EN_BIT 4
// =====================================================================
// Timing: one delay step is 125 ns, clock period is 20 ns.
`define PGDFC_STEP_NS 125
`define PGDFC_CLK_NS 20
// Longest-time style floor would give 6; a step must not be shorter, so round up.
`define PGDFC_STEP_CYCLES ((`PGDFC_STEP_NS + `PGDFC_CLK_NS - 1) / `PGDFC_CLK_NS)
// 500 s / 125 ns = 4e9 steps; needs a 32-bit counter.
`define PGDFC_MAX_STEPS 32'hee6b_2800
`endif

// File: pgdfc_pkg.sv
// Types shared by the power-good and fault config bank.
package pgdfc_pkg;
  typedef logic [15:0] pgdfc_word_t;
  typedef logic [7:0] pgdfc_byte_t;
  typedef enum logic [2:0] {
    PGDFC_PG_LOW = 3'b001,
    PGDFC_PG_WAIT = 3'b010,
    PGDFC_PG_GOOD = 3'b100
  } pgdfc_pg_e;
endpackage

// File: pgdfc_stage_model.sv
// Behavioural power stage: good comparator, OV/UV comparators and their sample strobe.
`timescale 1ns/1ps
module pgdfc_stage_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [1:0] good_req_i,
  input wire logic [1:0] ov_req_i,
  input wire logic [1:0] uv_req_i,
  output logic [1:0] above_good_o,
  output logic [1:0] ov_o,
  output logic [1:0] uv_o,
  output logic [1:0] sample_o
);
  logic [2:0] phase;
  // ==================================================================
  // Strobe period is 8 cycles, high for 4, so a 2-stage sync never misses one.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  assign sample_o = {2{phase[2]}};
  // Levels move only as the strobe falls, so every sample sees a settled level.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ov_o <= 2'h0;
      uv_o <= 2'h0;
    end else if (phase == 3'h7) begin
      ov_o <= ov_req_i;
      uv_o <= uv_req_i;
    end
  end
  // The good comparator follows the requested output level one cycle late.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      above_good_o <= 2'h0;
    end else begin
      above_good_o <= good_req_i;
    end
  end
endmodule
